// ===== rtl/tocc_map.svh
// register offsets, field positions and reset values of the compare channels
// assumes an 8-bit special function register space addressed by byte
`ifndef TOCC_MAP_SVH
`define TOCC_MAP_SVH

`define TOCC_OFF_CH0_CTRL     8'hCC
`define TOCC_OFF_CH0_LEVEL    8'hCD
`define TOCC_OFF_CH1_CTRL     8'hCE
`define TOCC_OFF_CH1_LEVEL    8'hCF
`define TOCC_OFF_SIB_COUNT    8'hEA

`define TOCC_CTRL_IM_BIT      6
`define TOCC_CTRL_ACT_HI      5
`define TOCC_CTRL_ACT_LO      3
`define TOCC_CTRL_EN_BIT      2
`define TOCC_CTRL_RSV_HI      1
`define TOCC_CTRL_RSV_LO      0
`define TOCC_CTRL_WMASK       8'h7F

`define TOCC_CTRL_RESET       8'h40
`define TOCC_LEVEL_RESET      8'h00
`define TOCC_RDATA_RESET      8'h00
`define TOCC_COUNT_ZERO       8'h00
`define TOCC_COUNT_TOP        8'hFF

`endif

// ===== rtl/tocc_pkg.sv
// types shared by the compare channel modules
// assumes nothing beyond the map header
package tocc_pkg;

  typedef enum logic [2:0] {
    TOCC_ACT_SET      = 3'h0,
    TOCC_ACT_CLR      = 3'h1,
    TOCC_ACT_TOG      = 3'h2,
    TOCC_ACT_SET_UP   = 3'h3,
    TOCC_ACT_CLR_UP   = 3'h4,
    TOCC_ACT_SET_ALT  = 3'h5,
    TOCC_ACT_CLR_ALT  = 3'h6,
    TOCC_ACT_NONE     = 3'h7
  } tocc_action_t;

  typedef enum logic [1:0] {
    TOCC_MODE_FREE    = 2'h0,
    TOCC_MODE_DOWN    = 2'h1,
    TOCC_MODE_MODULO  = 2'h2,
    TOCC_MODE_UPDOWN  = 2'h3
  } tocc_count_mode_t;

  typedef enum logic [1:0] {
    TOCC_PIN_KEEP     = 2'h0,
    TOCC_PIN_SET      = 2'h1,
    TOCC_PIN_CLR      = 2'h2,
    TOCC_PIN_TOG      = 2'h3
  } tocc_pin_op_t;

endpackage

// ===== rtl/tocc_cfg_if.sv
// configuration carried from the register file to the compare core
// assumes one clock domain, both ends on mclk
`timescale 1ns/1ps
interface tocc_cfg_if;
  import tocc_pkg::*;
  tocc_action_t action [2];
  logic [1:0]   cmp_en;
  logic [1:0]   irq_mask;
  logic [7:0]   level0;
  logic [7:0]   level1;
  logic         level0_wr;

  modport regs (output action, output cmp_en, output irq_mask, output level0, output level1, output level0_wr);
  modport core (input action, input cmp_en, input irq_mask, input level0, input level1, input level0_wr);
endinterface

// ===== rtl/tocc_regs.sv
// control and compare level registers of both channels
// assumes single-cycle write strobes from the cpu on mclk
`timescale 1ns/1ps
`include "tocc_map.svh"
module tocc_regs
  import tocc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // cpu write side
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  // read back
  output logic      [7:0] ctrl0_rd,
  output logic      [7:0] ctrl1_rd,
  // to the core
  tocc_cfg_if.regs        cfg
);

  logic [7:0] ctrl_q [2];
  logic [7:0] level_q [2];

  // bit 7 is held at zero and ignores writes
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      localparam logic [7:0] CTRL_OFF  = (g == 0) ? `TOCC_OFF_CH0_CTRL : `TOCC_OFF_CH1_CTRL;
      localparam logic [7:0] LEVEL_OFF = (g == 0) ? `TOCC_OFF_CH0_LEVEL : `TOCC_OFF_CH1_LEVEL;
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_q[g] <= `TOCC_CTRL_RESET;
        end else if (sfr_wr && sfr_addr == CTRL_OFF) begin
          ctrl_q[g] <= sfr_wdata & `TOCC_CTRL_WMASK;
        end
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          level_q[g] <= `TOCC_LEVEL_RESET;
        end else if (sfr_wr && sfr_addr == LEVEL_OFF) begin
          level_q[g] <= sfr_wdata;
        end
      end
      assign cfg.action[g]   = tocc_action_t'(ctrl_q[g][`TOCC_CTRL_ACT_HI:`TOCC_CTRL_ACT_LO]);
      assign cfg.cmp_en[g]   = ctrl_q[g][`TOCC_CTRL_EN_BIT];
      assign cfg.irq_mask[g] = ctrl_q[g][`TOCC_CTRL_IM_BIT];
    end
  endgenerate

  assign cfg.level0    = level_q[0];
  assign cfg.level1    = level_q[1];
  assign cfg.level0_wr = sfr_wr && sfr_addr == `TOCC_OFF_CH0_LEVEL;
  assign ctrl0_rd      = ctrl_q[0];
  assign ctrl1_rd      = ctrl_q[1];

endmodule

// ===== rtl/tocc_pin.sv
// one compare output pin: applies a pin operation on a clock edge
// assumes the operation is decided by the core in the same cycle
`timescale 1ns/1ps
module tocc_pin
  import tocc_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // operation
  input  wire tocc_pin_op_t op,
  // pin
  output logic              pin_q
);

  // a flop drives the pin so each change is a single clean edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'h0;
    end else begin
      unique case (op)
        TOCC_PIN_KEEP: pin_q <= pin_q;
        TOCC_PIN_SET:  pin_q <= 1'h1;
        TOCC_PIN_CLR:  pin_q <= 1'h0;
        TOCC_PIN_TOG:  pin_q <= ~pin_q;
      endcase
    end
  end

endmodule

// ===== rtl/tocc_top.sv
// top of the two compare channels with their cpu register port
// assumes count_byte, count_upd, count_down and count_mode come from the
// timer core on mclk, and sib_count from the sibling timer on mclk
`timescale 1ns/1ps
`include "tocc_map.svh"
module tocc_top
  import tocc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // cpu register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // timer core
  input  wire logic [7:0] count_byte,
  input  wire logic       count_upd,
  input  wire logic       count_down,
  input  wire logic [1:0] count_mode,
  output logic      [7:0] terminal_level,
  // sibling timer
  input  wire logic [7:0] sib_count,
  // compare outputs
  output logic      [1:0] compare_out,
  output logic      [1:0] channel_match_flag,
  output logic      [1:0] chan_irq_req
);

  tocc_cfg_if cfg ();

  logic [7:0]   ctrl0_rd;
  logic [7:0]   ctrl1_rd;
  logic [7:0]   level0_act_q;
  logic         level0_pend_q;
  logic [7:0]   rdata_q;
  logic [1:0]   flag_q;
  logic [1:0]   irq_q;
  logic [1:0]   hit;
  logic         at_zero;
  logic         at_top;
  logic         at_level0;
  logic         updown;
  tocc_pin_op_t pin_op [2];

  tocc_regs u_regs (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .ctrl0_rd  (ctrl0_rd),
    .ctrl1_rd  (ctrl1_rd),
    .cfg       (cfg.regs)
  );

  // channel 0 level is double buffered: a write waits for count 0x00 so a
  // running period is never cut short; channel 1 uses its register directly
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level0_pend_q <= 1'h0;
    end else if (cfg.level0_wr) begin
      level0_pend_q <= 1'h1;
    end else if (count_byte == `TOCC_COUNT_ZERO) begin
      level0_pend_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      level0_act_q <= `TOCC_LEVEL_RESET;
    end else if (level0_pend_q && count_byte == `TOCC_COUNT_ZERO) begin
      level0_act_q <= cfg.level0;
    end
  end

  assign terminal_level = level0_act_q;

  // events are sampled only when the counter has just taken a new value,
  // so a stopped timer never repeats a match
  assign at_zero   = count_upd && count_byte == `TOCC_COUNT_ZERO;
  assign at_top    = count_upd && count_byte == `TOCC_COUNT_TOP;
  assign at_level0 = count_upd && count_byte == level0_act_q;
  assign updown    = tocc_count_mode_t'(count_mode) == TOCC_MODE_UPDOWN;
  assign hit[0]    = cfg.cmp_en[0] && at_level0;
  assign hit[1]    = cfg.cmp_en[1] && count_upd && count_byte == cfg.level1;

  // decides the pin operation; a match takes priority over the second
  // event when both fall in the same count
  function automatic tocc_pin_op_t pin_decide(
    input tocc_action_t act,
    input logic         ch1,
    input logic         match,
    input logic         down,
    input logic         ud,
    input logic         zero,
    input logic         top,
    input logic         lvl0
  );
    tocc_pin_op_t op;
    op = TOCC_PIN_KEEP;
    unique case (act)
      TOCC_ACT_SET: begin
        if (match) op = TOCC_PIN_SET;
      end
      TOCC_ACT_CLR: begin
        if (match) op = TOCC_PIN_CLR;
      end
      TOCC_ACT_TOG: begin
        if (match) op = TOCC_PIN_TOG;
      end
      TOCC_ACT_SET_UP: begin
        if (ud) begin
          if (match) op = down ? TOCC_PIN_CLR : TOCC_PIN_SET;
        end else if (match) begin
          op = TOCC_PIN_SET;
        end else if (zero) begin
          op = TOCC_PIN_CLR;
        end
      end
      TOCC_ACT_CLR_UP: begin
        if (ud) begin
          if (match) op = down ? TOCC_PIN_SET : TOCC_PIN_CLR;
        end else if (match) begin
          op = TOCC_PIN_CLR;
        end else if (zero) begin
          op = TOCC_PIN_SET;
        end
      end
      TOCC_ACT_SET_ALT: begin
        if (match) begin
          op = TOCC_PIN_SET;
        end else if (ch1 ? lvl0 : top) begin
          op = TOCC_PIN_CLR;
        end
      end
      TOCC_ACT_CLR_ALT: begin
        if (match) begin
          op = TOCC_PIN_CLR;
        end else if (ch1 ? lvl0 : zero) begin
          op = TOCC_PIN_SET;
        end
      end
      TOCC_ACT_NONE: op = TOCC_PIN_KEEP;
    endcase
    return op;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // a disabled channel keeps its pin whatever the counter does
      always_comb begin
        if (!cfg.cmp_en[g]) begin
          pin_op[g] = TOCC_PIN_KEEP;
        end else begin
          pin_op[g] = pin_decide(cfg.action[g], g == 1, hit[g], count_down, updown,
                                 at_zero, at_top, at_level0);
        end
      end

      tocc_pin u_pin (
        .mclk    (mclk),
        .reset_n (reset_n),
        .op      (pin_op[g]),
        .pin_q   (compare_out[g])
      );

      // flag pulses on every enabled match; the request also needs the mask
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          flag_q[g] <= 1'h0;
        end else begin
          flag_q[g] <= hit[g];
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          irq_q[g] <= 1'h0;
        end else begin
          irq_q[g] <= hit[g] && cfg.irq_mask[g];
        end
      end
    end
  endgenerate

  assign channel_match_flag = flag_q;
  assign chan_irq_req       = irq_q;

  // read data is registered; unmapped addresses read as zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `TOCC_RDATA_RESET;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `TOCC_OFF_CH0_CTRL:  rdata_q <= ctrl0_rd;
        `TOCC_OFF_CH0_LEVEL: rdata_q <= cfg.level0;
        `TOCC_OFF_CH1_CTRL:  rdata_q <= ctrl1_rd;
        `TOCC_OFF_CH1_LEVEL: rdata_q <= cfg.level1;
        `TOCC_OFF_SIB_COUNT: rdata_q <= sib_count;
        default:             rdata_q <= `TOCC_RDATA_RESET;
      endcase
    end
  end

  assign sfr_rdata = rdata_q;

endmodule

// ===== verif/tocc_properties.sv
// assertions on the compare channel top ports
// assumes binding onto tocc_top, single clock mclk
`timescale 1ns/1ps
module tocc_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // timer side
  input wire logic [7:0] count_byte,
  input wire logic       count_upd,
  input wire logic [7:0] sib_count,
  input wire logic [7:0] terminal_level,
  // outputs
  input wire logic [1:0] compare_out,
  input wire logic [1:0] channel_match_flag,
  input wire logic [1:0] chan_irq_req
);
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [7:0] l1_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // write shadows, so actions are known without looking inside
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      c0_q <= 8'h40;
      c1_q <= 8'h40;
      l1_q <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'hCC) c0_q <= sfr_wdata;
      if (sfr_addr == 8'hCE) c1_q <= sfr_wdata;
      if (sfr_addr == 8'hCF) l1_q <= sfr_wdata;
    end
  end
  property p_irq_mask;
    chan_irq_req[0] |-> channel_match_flag[0] && $past(c0_q[6]);
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq without flag or mask");
  property p_flag_en;
    channel_match_flag[0] |-> $past(count_upd && c0_q[2]);
  endproperty
  a_flag_en: assert property (p_flag_en)
    else $error("flag while disabled or idle");
  property p_ch1_set;
    count_upd && c1_q[5:2] == 4'h1 && count_byte == l1_q |=> compare_out[1] && channel_match_flag[1];
  endproperty
  a_ch1_set: assert property (p_ch1_set)
    else $error("set action missed");
  property p_ch1_off;
    !c1_q[2] |=> !channel_match_flag[1] && $stable(compare_out[1]);
  endproperty
  a_ch1_off: assert property (p_ch1_off)
    else $error("disabled channel moved");
  property p_pin_upd;
    !$stable(compare_out) |-> $past(count_upd);
  endproperty
  a_pin_upd: assert property (p_pin_upd)
    else $error("pin moved without count update");
  property p_rd_sib;
    sfr_rd && sfr_addr == 8'hEA |=> sfr_rdata == $past(sib_count);
  endproperty
  a_rd_sib: assert property (p_rd_sib)
    else $error("sibling count read wrong");
  property p_rd_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_ctrl_top;
    sfr_rd && (sfr_addr == 8'hCC || sfr_addr == 8'hCE) |=> !sfr_rdata[7];
  endproperty
  a_ctrl_top: assert property (p_ctrl_top)
    else $error("control bit 7 not zero");
  // the active channel 0 level may only move right after the count sat at zero
  property p_term_zero;
    !$stable(terminal_level) |-> $past(count_byte) == 8'h00;
  endproperty
  a_term_zero: assert property (p_term_zero)
    else $error("terminal level moved away from count zero");
endmodule
bind tocc_top tocc_properties u_props (
  .mclk               (mclk),
  .reset_n            (reset_n),
  .sfr_addr           (sfr_addr),
  .sfr_wr             (sfr_wr),
  .sfr_wdata          (sfr_wdata),
  .sfr_rd             (sfr_rd),
  .sfr_rdata          (sfr_rdata),
  .count_byte         (count_byte),
  .count_upd          (count_upd),
  .sib_count          (sib_count),
  .terminal_level     (terminal_level),
  .compare_out        (compare_out),
  .channel_match_flag (channel_match_flag),
  .chan_irq_req       (chan_irq_req)
);

// ===== verif/tocc_top_tb_top.sv
// self-checking bench for the compare channel top
// assumes the bench plays both the cpu and the timer core
`timescale 1ns/1ps
module tocc_top_tb_top;
  import tocc_pkg::*;
  logic       mclk, reset_n, sfr_wr, sfr_rd, count_upd, count_down;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, count_byte, sib_count, terminal_level;
  logic [1:0] count_mode, compare_out, channel_match_flag, chan_irq_req;
  logic [7:0] ctl [2];
  logic [7:0] tbl [4];
  logic [7:0] lv0r, lv0a, lv1, erd, x;
  logic [1:0] pin, ef, ei;
  logic       pend, en;
  integer     seed = 67031, error_cnt = 0, total_checks = 0;
  logic [7:0] regs [8] = '{8'hCC, 8'hCD, 8'hCE, 8'hCF, 8'hEA, 8'h00, 8'hCB, 8'hEB};
  tocc_top DUT (
    .mclk               (mclk),
    .reset_n            (reset_n),
    .sfr_addr           (sfr_addr),
    .sfr_wr             (sfr_wr),
    .sfr_wdata          (sfr_wdata),
    .sfr_rd             (sfr_rd),
    .sfr_rdata          (sfr_rdata),
    .count_byte         (count_byte),
    .count_upd          (count_upd),
    .count_down         (count_down),
    .count_mode         (count_mode),
    .terminal_level     (terminal_level),
    .sib_count          (sib_count),
    .compare_out        (compare_out),
    .channel_match_flag (channel_match_flag),
    .chan_irq_req       (chan_irq_req)
  );
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: pins %b, model %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: byte %h, model %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // counts only come from the table, so matches, zero and 0xFF are frequent
  task automatic step(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] y;
    @(negedge mclk);
    y = $random(seed);
    sfr_wr = w;
    sfr_rd = r;
    sfr_addr = a;
    sfr_wdata = d;
    count_upd = y[2];
    count_down = y[3];
    count_byte = tbl[y[1:0]];
    sib_count = y[15:8];
  endtask
  always @(posedge mclk or negedge reset_n) begin : model
    logic m, s, ud;
    logic [2:0] a;
    logic [7:0] c;
    if (!reset_n) begin
      ctl = '{8'h40, 8'h40};
      {lv0r, lv0a, lv1, erd, pin, ef, ei, pend} = '0;
    end else begin
      c = count_byte;
      ud = count_mode == TOCC_MODE_UPDOWN;
      for (int n = 0; n < 2; n++) begin
        a = ctl[n][5:3];
        m = count_upd && ctl[n][2] && c == (n ? lv1 : lv0a);
        s = (a == 3'h5 && n == 0) ? c == 8'hFF : (a > 3'h4 && n == 1) ? c == lv0a : c == 8'h00;
        ef[n] = m;
        ei[n] = m && ctl[n][6];
        if (m) case (a)
          3'h0, 3'h5: pin[n] = 1'b1;
          3'h1, 3'h6: pin[n] = 1'b0;
          3'h2: pin[n] = ~pin[n];
          3'h3: pin[n] = !(ud && count_down);
          3'h4: pin[n] = ud && count_down;
          default: ;
        endcase
        else if (count_upd && ctl[n][2] && s && (a == 3'h5 || a == 3'h6 || !ud && (a == 3'h3 || a == 3'h4)))
          pin[n] = (a == 3'h4 || a == 3'h6);
      end
      if (pend && c == 8'h00) begin
        lv0a = lv0r;
        pend = 1'b0;
      end
      if (sfr_rd) erd = sfr_addr == 8'hCC ? ctl[0] : sfr_addr == 8'hCD ? lv0r : sfr_addr == 8'hCE ? ctl[1] :
                        sfr_addr == 8'hCF ? lv1 : sfr_addr == 8'hEA ? sib_count : 8'h00;
      if (sfr_wr) case (sfr_addr)
        8'hCC: ctl[0] = sfr_wdata & 8'h7F;
        8'hCD: {lv0r, pend} = {sfr_wdata, 1'b1};
        8'hCE: ctl[1] = sfr_wdata & 8'h7F;
        8'hCF: lv1 = sfr_wdata;
        default: ;
      endcase
    end
  end
  always @(negedge mclk) if (reset_n) begin
    chk_pin(compare_out, pin);
    chk_pin(channel_match_flag, ef);
    chk_pin(chan_irq_req, ei);
    chk_byte(sfr_rdata, erd);
    chk_byte(terminal_level, lv0a);
  end
  initial begin
    {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, count_byte, count_upd, count_down, count_mode, sib_count} = '0;
    tbl = '{8'h00, 8'hFF, 8'h10, 8'h20};
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    for (int k = 0; k < 8; k++) step(1'b0, 1'b1, regs[k], 8'h00);
    for (int t = 0; t < 16; t++) begin
      x = 8'($random(seed));
      count_mode = t[3] ? 2'h3 : x[1:0];
      en = x[2] | x[3];
      tbl[2] = 8'($random(seed));
      tbl[3] = 8'($random(seed));
      step(1'b1, 1'b0, 8'hCD, tbl[2]);
      step(1'b1, 1'b0, 8'hCF, tbl[3]);
      step(1'b1, 1'b0, 8'hCC, {1'b0, x[6], t[2:0], en, 2'b00});
      step(1'b1, 1'b0, 8'hCE, {1'b1, x[7], t[2:0], en | x[4], 2'b00});
      step(1'b1, 1'b0, 8'hEA, x);
      for (int k = 0; k < 80; k++) step(1'b0, k[0], regs[k[3:1]], 8'h00);
      $display("test %0d with action %0d done", t, t[2:0]);
    end
    // reset in mid-run: dropped after the checks of this edge so model and design fall together
    @(negedge mclk) reset_n <= 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (int k = 0; k < 8; k++) step(1'b0, 1'b1, regs[k], 8'h00);
    $display("test reset in mid-run done");
    stop_test();
  end
endmodule
